// ==== hw/rfm_response_framer.sv ====
// response framer: builds unsolicited and error frames for the host link
module rfm_response_framer
  import rfm_pkg::*;
#(
  parameter int         GPI_W        = 8,
  parameter logic [7:0] HDR_NOTE     = 8'hb0, // arbitrary default
  parameter logic [7:0] CODE_OVR_EXE = 8'h4b, // arbitrary default
  parameter logic [7:0] CODE_OVR_INT = 8'h4c, // arbitrary default
  parameter logic [7:0] CODE_EVT_EXE = 8'h4d, // arbitrary default
  parameter logic [7:0] HDR_GPI      = 8'hc0  // arbitrary default
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  // unit identity
  input  wire logic [rfm_pkg::RFM_ADDR_W-1:0] unit_addr,
  // events from the instruction decoder and queues
  input  wire logic                        cmd_err_pulse,
  input  wire logic                        ovr_exec_pulse,
  input  wire logic                        ovr_err_pulse,
  input  wire logic                        evt_exec_pulse,
  input  wire logic                        evt_err_pulse,
  // pulse generator stop report
  input  wire logic                        stop_pulse,
  input  wire rfm_pkg::rfm_stop_e          stop_cause,
  // general-purpose inputs, pins are asynchronous
  input  wire logic [GPI_W-1:0]            gpi_pin,
  input  wire logic [GPI_W-1:0]            gpi_mask,
  // queue control back to the executor
  output logic                             ovr_halt,
  output logic                             ovr_flush,
  output logic                             evt_halt,
  output logic                             evt_flush,
  // response byte stream toward the link transmitter
  output logic [7:0]                       tx_data,
  output logic                             tx_valid,
  output logic                             tx_first,
  output logic                             tx_last,
  input  wire logic                        tx_ready
);

  // ****************************************************************
  // input synchronisers and change detection
  // ****************************************************************
  logic [GPI_W-1:0]     gpi_meta_r;
  logic [GPI_W-1:0]     gpi_sync_r;
  logic [GPI_W-1:0]     gpi_prev_r;
  logic [GPI_W-1:0]     gpi_snap_r;
  logic [GPI_W-1:0]     gpi_diff;
  logic                 gpi_chg;

  // pins pass two flops; only the second one is looked at
  always_ff @(posedge sys_clk) begin
    gpi_meta_r <= gpi_pin;
    gpi_sync_r <= gpi_meta_r;
  end

  // masked-off inputs never raise a response
  assign gpi_diff = (gpi_sync_r ^ gpi_prev_r) & gpi_mask;
  assign gpi_chg  = |gpi_diff;

  // reference level tracks the synced pins so one edge gives one report
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gpi_prev_r <= '0;
    end else begin
      gpi_prev_r <= gpi_sync_r;
    end
  end

  // ****************************************************************
  // pending events, set beats clear
  // ****************************************************************
  logic [RFM_NSRC-1:0]  pend_r;
  logic [RFM_NSRC-1:0]  pend_nxt;
  logic [RFM_NSRC-1:0]  pend_set;
  logic [RFM_NSRC-1:0]  pend_clr;
  logic [RFM_NSRC-1:0]  pick_oh;
  logic                 any_pend;
  rfm_stop_e            cause_r;
  logic                 armed_r;

  assign pend_set[RFM_SRC_EVT_E] = evt_err_pulse;
  assign pend_set[RFM_SRC_OVR_E] = ovr_err_pulse;
  assign pend_set[RFM_SRC_CMD_E] = cmd_err_pulse;
  assign pend_set[RFM_SRC_STOP]  = stop_pulse;
  assign pend_set[RFM_SRC_OVR_X] = ovr_exec_pulse;
  assign pend_set[RFM_SRC_EVT_X] = evt_exec_pulse;
  // first cycle after reset only loads the reference, no false change
  assign pend_set[RFM_SRC_GPI]   = gpi_chg & armed_r;

  // fixed priority: isolate lowest set bit, errors first
  assign pick_oh  = pend_r & (~pend_r + 7'h01);
  assign any_pend = |pend_r;

  logic                 start_frame;
  rfm_state_e           state_r;
  rfm_state_e           state_nxt;

  assign start_frame = (state_r == RFM_ST_IDLE) & any_pend;
  assign pend_clr    = start_frame ? pick_oh : '0;
  // an event landing in the cycle it is taken is kept for a new frame
  assign pend_nxt    = (pend_r & ~pend_clr) | pend_set;

  // latest stop cause and input level are the ones reported
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_r     <= '0;
      armed_r    <= 1'b0;
      cause_r    <= RFM_STOP_ALARM;
      gpi_snap_r <= '0;
    end else begin
      pend_r  <= pend_nxt;
      armed_r <= 1'b1;
      if (stop_pulse) begin
        cause_r <= stop_cause;
      end
      if (pend_set[RFM_SRC_GPI]) begin
        gpi_snap_r <= gpi_sync_r & gpi_mask;
      end
    end
  end

  // ****************************************************************
  // queue abort on error inside a queued instruction
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovr_halt  <= 1'b0;
      ovr_flush <= 1'b0;
      evt_halt  <= 1'b0;
      evt_flush <= 1'b0;
    end else begin
      ovr_halt  <= ovr_err_pulse;
      ovr_flush <= ovr_err_pulse;
      evt_halt  <= evt_err_pulse;
      evt_flush <= evt_err_pulse;
    end
  end

  // ****************************************************************
  // frame byte selection
  // ****************************************************************
  logic [7:0]           addr_ext;
  logic [7:0]           end_code;
  logic [7:0]           sel_hdr;
  logic [7:0]           sel_code;
  logic [7:0]           hdr_r;
  logic [7:0]           code_r;
  logic [7:0]           gpi_byte;

  assign addr_ext = {{(8 - RFM_ADDR_W){1'b0}}, unit_addr};
  // wider inputs are cut to their low byte in the report
  assign gpi_byte = 8'(gpi_snap_r);

  // stop cause to byte
  assign end_code =
    (cause_r == RFM_STOP_ALARM)   ? RFM_END_ALARM    :
    (cause_r == RFM_STOP_ORIGIN)  ? RFM_END_ORIGIN   :
    (cause_r == RFM_STOP_LIMIT)   ? RFM_END_LIMIT    :
    (cause_r == RFM_STOP_HSLIMIT) ? RFM_END_HSLIMIT  :
    (cause_r == RFM_STOP_DEC_CMD) ? RFM_END_DEC_CMD  :
    (cause_r == RFM_STOP_IMM_CMD) ? RFM_END_IMM_CMD  :
    (cause_r == RFM_STOP_NORMAL)  ? RFM_END_NORMAL   :
                                    RFM_END_MIN_RATE;

  // header base for the winning source
  assign sel_hdr =
    pick_oh[RFM_SRC_STOP]  ? RFM_HDR_STOP + addr_ext :
    pick_oh[RFM_SRC_GPI]   ? HDR_GPI + addr_ext      :
    pick_oh[RFM_SRC_OVR_X] ? HDR_NOTE + addr_ext     :
    pick_oh[RFM_SRC_EVT_X] ? HDR_NOTE + addr_ext     :
                             RFM_HDR_ERR + addr_ext;

  // code byte for the winning source
  assign sel_code =
    pick_oh[RFM_SRC_EVT_E] ? RFM_CODE_EVT_INT :
    pick_oh[RFM_SRC_OVR_E] ? CODE_OVR_INT     :
    pick_oh[RFM_SRC_CMD_E] ? RFM_CODE_CMD_ERR :
    pick_oh[RFM_SRC_STOP]  ? end_code         :
    pick_oh[RFM_SRC_OVR_X] ? CODE_OVR_EXE     :
    pick_oh[RFM_SRC_EVT_X] ? CODE_EVT_EXE     :
                             gpi_byte;

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  logic                 byte_done;
  logic [7:0]           tx_data_nxt;
  logic [7:0]           csum;

  assign byte_done = tx_valid & tx_ready;
  // modulo-256 sum of the bytes before it, as on received frames
  assign csum      = hdr_r + code_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFM_ST_IDLE: begin
        if (any_pend) begin
          state_nxt = RFM_ST_HDR;
        end
      end
      RFM_ST_HDR: begin
        if (tx_ready) begin
          state_nxt = RFM_ST_CODE;
        end
      end
      RFM_ST_CODE: begin
        if (tx_ready) begin
          state_nxt = RFM_ST_SUM;
        end
      end
      RFM_ST_SUM: begin
        if (tx_ready) begin
          state_nxt = RFM_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RFM_ST_IDLE;
      end
    endcase
  end

  // data register always holds the byte now being offered
  assign tx_data_nxt =
    start_frame                          ? sel_hdr :
    (byte_done & state_r == RFM_ST_HDR)  ? code_r  :
    (byte_done & state_r == RFM_ST_CODE) ? csum    :
                                           tx_data;

  // frame bytes are frozen at start so late events cannot tear a frame
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= RFM_ST_IDLE;
      hdr_r   <= '0;
      code_r  <= '0;
      tx_data <= '0;
    end else begin
      state_r <= state_nxt;
      tx_data <= tx_data_nxt;
      if (start_frame) begin
        hdr_r  <= sel_hdr;
        code_r <= sel_code;
      end
    end
  end

  // handshake flags follow the state directly
  assign tx_valid = (state_r != RFM_ST_IDLE);
  assign tx_first = (state_r == RFM_ST_HDR);
  assign tx_last  = (state_r == RFM_ST_SUM);

endmodule : rfm_response_framer

// ==== pkg/rfm_pkg.sv ====
// constants and types shared by the motion controller response framer
package rfm_pkg;

  // ****************************************************************
  // frame header bases, unit address is added to the low nibble
  // ****************************************************************
  localparam logic [7:0] RFM_HDR_ERR     = 8'hb0;
  localparam logic [7:0] RFM_HDR_STOP    = 8'ha0;
  localparam int         RFM_ADDR_W      = 4;

  // ****************************************************************
  // response code bytes
  // ****************************************************************
  localparam logic [7:0] RFM_CODE_CMD_ERR = 8'h47;
  localparam logic [7:0] RFM_CODE_EVT_INT = 8'h4a;

  // stop-cause bytes carried in the pulse output stop frame
  localparam logic [7:0] RFM_END_ALARM    = 8'h31;
  localparam logic [7:0] RFM_END_ORIGIN   = 8'h32;
  localparam logic [7:0] RFM_END_LIMIT    = 8'h33;
  localparam logic [7:0] RFM_END_HSLIMIT  = 8'h34;
  localparam logic [7:0] RFM_END_DEC_CMD  = 8'h36;
  localparam logic [7:0] RFM_END_IMM_CMD  = 8'h37;
  localparam logic [7:0] RFM_END_NORMAL   = 8'h38;
  localparam logic [7:0] RFM_END_MIN_RATE = 8'h39;

  // ****************************************************************
  // external reset hold after clock start
  // ****************************************************************
  localparam int RFM_RST_HOLD_US = 500;
  localparam int RFM_CLK_MHZ     = 100;
  localparam int RFM_RST_HOLD_CYC = RFM_RST_HOLD_US * RFM_CLK_MHZ;

  // ****************************************************************
  // source indices, lower index wins arbitration
  // ****************************************************************
  localparam int RFM_NSRC      = 7;
  localparam int RFM_SRC_EVT_E = 0;
  localparam int RFM_SRC_OVR_E = 1;
  localparam int RFM_SRC_CMD_E = 2;
  localparam int RFM_SRC_STOP  = 3;
  localparam int RFM_SRC_OVR_X = 4;
  localparam int RFM_SRC_EVT_X = 5;
  localparam int RFM_SRC_GPI   = 6;

  // stop cause reported by the pulse generator
  typedef enum logic [2:0] {
    RFM_STOP_ALARM    = 3'b000,
    RFM_STOP_ORIGIN   = 3'b001,
    RFM_STOP_LIMIT    = 3'b010,
    RFM_STOP_HSLIMIT  = 3'b011,
    RFM_STOP_DEC_CMD  = 3'b100,
    RFM_STOP_IMM_CMD  = 3'b101,
    RFM_STOP_NORMAL   = 3'b110,
    RFM_STOP_MIN_RATE = 3'b111
  } rfm_stop_e;

  // frame transmit sequencer
  typedef enum logic [1:0] {
    RFM_ST_IDLE = 2'b00,
    RFM_ST_HDR  = 2'b01,
    RFM_ST_CODE = 2'b10,
    RFM_ST_SUM  = 2'b11
  } rfm_state_e;

endpackage : rfm_pkg

// ==== verif/rfm_response_framer_monitor.sv ====
// assertion checker watching the response framer ports
module rfm_response_framer_monitor
  import rfm_pkg::*;
(
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           srst,
  // event side
  input wire logic [rfm_pkg::RFM_ADDR_W-1:0] unit_addr,
  input wire logic                           ovr_err_pulse,
  input wire logic                           evt_err_pulse,
  input wire logic                           stop_pulse,
  input wire rfm_pkg::rfm_stop_e             stop_cause,
  // queue control
  input wire logic                           ovr_halt,
  input wire logic                           ovr_flush,
  input wire logic                           evt_halt,
  input wire logic                           evt_flush,
  // link
  input wire logic [7:0]                     tx_data,
  input wire logic                           tx_valid,
  input wire logic                           tx_first,
  input wire logic                           tx_last,
  input wire logic                           tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic [7:0]      hdr_r;
  logic [7:0]      code_r;
  rfm_stop_e       cause_r;
  rfm_stop_e       frm_cause_r;
  wire logic       acc_w      = tx_valid && tx_ready;
  wire logic       mid_w      = tx_valid && !tx_first && !tx_last;
  wire logic       stop_hdr_w = (hdr_r == RFM_HDR_STOP + unit_addr);
  // cause byte skips 35, so the upper four causes are one higher
  wire logic [7:0] stop_code_w = 8'h31 + {5'h0, frm_cause_r} +
                                 {7'h0, frm_cause_r[2]};

  // remember header, code and causes to judge later bytes
  always_ff @(posedge sys_clk) begin
    if (stop_pulse) begin
      cause_r <= stop_cause;
    end
    // the framer freezes its cause when a frame starts, so a stop that
    // lands mid-frame must not move the expected byte
    if (!tx_valid) begin
      frm_cause_r <= cause_r;
    end
    if (acc_w && tx_first) begin
      hdr_r <= tx_data;
    end
    if (acc_w && mid_w) begin
      code_r <= tx_data;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_OVR_CTRL: assert property (
    ovr_err_pulse |=> ovr_halt && ovr_flush)
    else $error("override halt or flush missing");
  AST_EVT_CTRL: assert property (
    evt_err_pulse |=> evt_halt && evt_flush)
    else $error("event halt or flush missing");
  AST_HALT_CAUSE: assert property (
    ovr_halt || ovr_flush |-> $past(ovr_err_pulse))
    else $error("override halt without error");
  AST_HDR_ADDR: assert property (
    tx_valid && tx_first |-> tx_data[3:0] == unit_addr && !tx_last)
    else $error("header low nibble not unit address");
  AST_MID: assert property (
    acc_w && tx_first |=> mid_w)
    else $error("code byte does not follow header");
  AST_END: assert property (
    acc_w && mid_w |=> tx_valid && tx_last)
    else $error("checksum byte does not follow code");
  AST_GAP: assert property (
    acc_w && tx_last |=> !tx_valid)
    else $error("no idle cycle after frame");
  AST_HOLD: assert property (
    tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_first) &&
      $stable(tx_last))
    else $error("byte changed while stalled");
  AST_SUM: assert property (
    tx_valid && tx_last |-> tx_data == hdr_r + code_r)
    else $error("checksum byte wrong");
  AST_STOP_CODE: assert property (
    mid_w && stop_hdr_w |-> tx_data == stop_code_w)
    else $error("stop cause byte wrong");

  // main scenarios
  COV_STOP: cover property (acc_w && tx_last && hdr_r[7:4] == 4'ha);
  COV_EVT_ERR: cover property (evt_err_pulse);
  COV_STALL: cover property (tx_valid && !tx_ready);
  COV_GPI: cover property (acc_w && tx_first && tx_data[7:4] == 4'hc);
endmodule : rfm_response_framer_monitor

// ==== verif/rfm_link_sink.sv ====
// link sink model taking response bytes, with optional random stalls
module rfm_link_sink (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // byte stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_first,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // stall control and delivered bytes
  input  wire logic       slow,
  output logic            got,
  output logic [7:0]      got_data,
  output logic [1:0]      got_fl
);
  timeunit 1ns;
  timeprecision 100ps;
  int seed_v = 32'hccbd696f;
  initial tx_ready = 1'b1;
  initial got = 1'b0;
  // capture at the accepting edge, then move ready just after it
  always @(posedge sys_clk) begin
    got <= tx_valid && tx_ready && !srst;
    got_data <= tx_data;
    got_fl <= {tx_first, tx_last};
    #1;
    tx_ready <= !slow || ($random(seed_v) % 2 == 0);
  end
endmodule : rfm_link_sink

// ==== verif/tb.sv ====
// self-checking bench for the response framer
module tb
  import rfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, srst, slow, tx_ready, got;
  logic ovr_halt, ovr_flush, evt_halt, evt_flush, tx_valid, tx_first, tx_last;
  logic [3:0] addr;
  logic [5:0] ev;
  logic [7:0] pin, mask, tx_data, got_data, hf;
  logic [1:0] got_fl;
  rfm_stop_e  cause;
  int seed, miscompares, tests_run;
  logic [7:0] codes [5] = '{8'h47, 8'h4b, 8'h4c, 8'h4d, 8'h4a};
  rfm_response_framer u_dut (.sys_clk, .srst, .unit_addr(addr),
    .cmd_err_pulse(ev[0]), .ovr_exec_pulse(ev[1]), .ovr_err_pulse(ev[2]),
    .evt_exec_pulse(ev[3]), .evt_err_pulse(ev[4]), .stop_pulse(ev[5]),
    .stop_cause(cause), .gpi_pin(pin), .gpi_mask(mask), .ovr_halt,
    .ovr_flush, .evt_halt, .evt_flush, .tx_data, .tx_valid, .tx_first,
    .tx_last, .tx_ready);
  rfm_link_sink u_sink (.sys_clk, .srst, .tx_data, .tx_valid, .tx_first,
    .tx_last, .tx_ready, .slow, .got, .got_data, .got_fl);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic test_done();
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic cmp8(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask : cmp8
  // stop causes map onto 31..34 and 36..39, 35 unused
  function automatic logic [7:0] stop_code(input rfm_stop_e c);
    logic [7:0] t [8];
    t = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h36, 8'h37, 8'h38, 8'h39};
    return t[c];
  endfunction : stop_code
  task automatic fire(input logic [5:0] v);
    ev = v;
    tick();
    ev = 6'h0;
  endtask : fire
  // bounded wait for each of three bytes; sum is header plus code
  task automatic get_frame(input logic [7:0] hdr, input logic [7:0] code);
    logic [7:0] e [3];
    logic [7:0] fl;
    int n;
    e = '{hdr, code, hdr + code};
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin
        tick();
        n++;
      end while (got !== 1'b1 && n < 300);
      // a byte seen on the very last try still counts
      if (got !== 1'b1) begin
        $display("[ERR] frame byte expected %h seen none", e[i]);
        miscompares++;
        test_done();
      end
      fl = {6'h0, i == 0, i == 2};
      cmp8("frame byte", e[i], got_data);
      cmp8("frame flags", fl, {6'h0, got_fl});
    end
  endtask : get_frame
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 32'hccbd696f;
    srst = 1'b1;
    ev = 6'h0;
    addr = 4'h0;
    cause = RFM_STOP_ALARM;
    pin = 8'h00;
    mask = 8'h0f;
    slow = 1'b0;
    repeat (2) @(posedge sys_clk);
    // short hold stands in for the host's long settle time
    #1 srst = 1'b0;
    for (int c = 0; c < 8; c++) begin
      slow = c[0];
      addr = 4'($random(seed));
      cause = rfm_stop_e'(c);
      fire(6'h20);
      get_frame(8'ha0 + addr, stop_code(cause));
    end
    for (int k = 0; k < 5; k++) begin
      addr = 4'($random(seed));
      // halt and flush stand only in the cycle right after the pulse
      fire(6'h1 << k);
      hf = {4'h0, ovr_halt, ovr_flush, evt_halt, evt_flush};
      cmp8("halt flush", {4'h0, k == 2, k == 2, k == 4, k == 4}, hf);
      get_frame(8'hb0 + addr, codes[k]);
    end
    // two errors at once: event interruption is served first
    fire(6'h11);
    get_frame(8'hb0 + addr, 8'h4a);
    get_frame(8'hb0 + addr, 8'h47);
    // pulse held into the cycle it is taken: set wins, two frames follow
    ev = 6'h01;
    tick();
    fire(6'h01);
    get_frame(8'hb0 + addr, 8'h47);
    get_frame(8'hb0 + addr, 8'h47);
    // masked-off inputs toggle: nothing may be sent
    pin = pin ^ (8'hf0 & 8'($random(seed))) ^ 8'h10;
    for (int i = 0; i < 12; i++) begin
      tick();
      cmp8("quiet link", 8'h00, {7'h0, tx_valid});
    end
    pin = pin ^ 8'h05;
    get_frame(8'hc0 + addr, pin & mask);
    test_done();
  end
endmodule : tb
bind rfm_response_framer rfm_response_framer_monitor u_mon (.sys_clk, .srst,
  .unit_addr, .ovr_err_pulse, .evt_err_pulse, .stop_pulse, .stop_cause,
  .ovr_halt, .ovr_flush, .evt_halt, .evt_flush, .tx_data, .tx_valid,
  .tx_first, .tx_last, .tx_ready);
